// >>> verilog/cmsr_cfg.svh
`ifndef CMSR_CFG_SVH
`define CMSR_CFG_SVH

// ==========================================================================
// register offsets
`define CMSR_ADDR_SEL_HIGH     8'h8A
`define CMSR_ADDR_SEL_LOW_EN   8'h8B
`define CMSR_ADDR_SKEW1        8'h8C
`define CMSR_ADDR_SKEW2        8'h8D
`define CMSR_ADDR_SKEW3        8'h8E
`define CMSR_ADDR_SKEW4        8'h8F

// ==========================================================================
// field positions
`define CMSR_SEL_HIGH_LSB      0
`define CMSR_SEL_LOW_LSB       4
`define CMSR_OFS_EN_LSB        0

// ==========================================================================
// reset values
`define CMSR_RST_SEL_HIGH      4'hF
`define CMSR_RST_SEL_LOW_EN    8'hFF
`define CMSR_RST_SKEW1         8'h00
`define CMSR_RST_SKEW2         8'h01
`define CMSR_RST_SKEW3         8'h00
`define CMSR_RST_SKEW4         8'h00
`define CMSR_RSVD_HIGH         4'h0
`define CMSR_RD_UNMAPPED       8'h00

// ==========================================================================
// loss monitor timing, in reference clock periods
`define CMSR_WIN_FULL          16'h0010
`define CMSR_WIN_REDUCED       16'h0100
`define CMSR_THR_FULL          4'h1
`define CMSR_THR_REDUCED       4'h4
`define CMSR_WIN_OFF           16'h0000
`define CMSR_THR_OFF           4'h0

`endif

// >>> verilog/cmsr_pkg.sv
package cmsr_pkg;

  // ========================================================================
  // loss monitor select codes
  typedef enum logic [1:0] {
    CMSR_LOS_OFF      = 2'h0,
    CMSR_LOS_RESERVED = 2'h1,
    CMSR_LOS_REDUCED  = 2'h2,
    CMSR_LOS_FULL     = 2'h3
  } cmsr_los_mode_t;

  // ========================================================================
  // per-input loss monitor setup
  typedef struct packed {
    cmsr_los_mode_t mode;
    logic           active;
    logic [15:0]    window;
    logic [3:0]     threshold;
  } cmsr_mon_cfg_t;

  // ========================================================================
  // output phase skews
  typedef struct packed {
    logic signed [7:0] out4;
    logic signed [7:0] out3;
    logic signed [7:0] out2;
    logic signed [7:0] out1;
  } cmsr_skew_t;

  // ========================================================================
  // register bank state
  typedef struct packed {
    logic [3:0] sel_high;
    logic [7:0] sel_low_en;
    cmsr_skew_t skew;
    logic [7:0] rdata;
    logic       rvalid;
  } cmsr_state_t;

endpackage : cmsr_pkg

// >>> verilog/cmsr_los_decode.sv
`timescale 1ns/1ns
`include "cmsr_cfg.svh"

module cmsr_los_decode
(
  input  wire logic          sel_high_in,
  input  wire logic          sel_low_in,
  output cmsr_pkg::cmsr_mon_cfg_t cfg_out
);

  // ========================================================================
  // select decode
  always_comb
  begin
    cfg_out = '0;
    unique case ({sel_high_in, sel_low_in})
      2'b11:
      begin
        cfg_out.mode      = cmsr_pkg::CMSR_LOS_FULL;
        cfg_out.active    = 1'b1;
        cfg_out.window    = `CMSR_WIN_FULL;
        cfg_out.threshold = `CMSR_THR_FULL;
      end
      2'b10:
      begin
        cfg_out.mode      = cmsr_pkg::CMSR_LOS_REDUCED;
        cfg_out.active    = 1'b1;
        cfg_out.window    = `CMSR_WIN_REDUCED;
        cfg_out.threshold = `CMSR_THR_REDUCED;
      end
      2'b01:
      begin
        cfg_out.mode      = cmsr_pkg::CMSR_LOS_RESERVED;
        cfg_out.active    = 1'b0;
        cfg_out.window    = `CMSR_WIN_OFF;
        cfg_out.threshold = `CMSR_THR_OFF;
      end
      2'b00:
      begin
        cfg_out.mode      = cmsr_pkg::CMSR_LOS_OFF;
        cfg_out.active    = 1'b0;
        cfg_out.window    = `CMSR_WIN_OFF;
        cfg_out.threshold = `CMSR_THR_OFF;
      end
    endcase
  end

endmodule : cmsr_los_decode

// >>> verilog/cmsr_regs.sv
`timescale 1ns/1ns
`include "cmsr_cfg.svh"

module cmsr_regs
#(
  parameter int NUM_INPUTS = 4
)
(
  input  wire logic                    mclk_in,
  input  wire logic                    nrst_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire logic [7:0]              reg_wdata_in,
  output logic      [7:0]              reg_rdata_out,
  output logic                         reg_rvalid_out,
  output cmsr_pkg::cmsr_mon_cfg_t [NUM_INPUTS-1:0] loss_cfg_out,
  output logic      [NUM_INPUTS-1:0]   offset_monitor_enable_out,
  output cmsr_pkg::cmsr_skew_t         phase_skew_out
);

  cmsr_pkg::cmsr_state_t st_r;
  cmsr_pkg::cmsr_state_t st_nxt;

  // ========================================================================
  // read mux
  function automatic logic [7:0] read_word
  (
    input logic [7:0]            addr,
    input cmsr_pkg::cmsr_state_t s
  );
    logic [7:0] d;
    d = `CMSR_RD_UNMAPPED;
    unique case (addr)
      `CMSR_ADDR_SEL_HIGH:   d = {`CMSR_RSVD_HIGH, s.sel_high};
      `CMSR_ADDR_SEL_LOW_EN: d = s.sel_low_en;
      `CMSR_ADDR_SKEW1:      d = s.skew.out1;
      `CMSR_ADDR_SKEW2:      d = s.skew.out2;
      `CMSR_ADDR_SKEW3:      d = s.skew.out3;
      `CMSR_ADDR_SKEW4:      d = s.skew.out4;
      default:               d = `CMSR_RD_UNMAPPED;
    endcase
    return d;
  endfunction : read_word

  // ========================================================================
  // next state
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = reg_rd_in;
    if (reg_rd_in)
    begin
      st_nxt.rdata = read_word(reg_addr_in, st_r);
    end
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        `CMSR_ADDR_SEL_HIGH:   st_nxt.sel_high   = reg_wdata_in[3:0];
        `CMSR_ADDR_SEL_LOW_EN: st_nxt.sel_low_en = reg_wdata_in;
        `CMSR_ADDR_SKEW1:      st_nxt.skew.out1  = reg_wdata_in;
        `CMSR_ADDR_SKEW2:      st_nxt.skew.out2  = reg_wdata_in;
        `CMSR_ADDR_SKEW3:      st_nxt.skew.out3  = reg_wdata_in;
        `CMSR_ADDR_SKEW4:      st_nxt.skew.out4  = reg_wdata_in;
        default:               st_nxt.rvalid     = st_nxt.rvalid;
      endcase
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_r            <= '0;
      st_r.sel_high   <= `CMSR_RST_SEL_HIGH;
      st_r.sel_low_en <= `CMSR_RST_SEL_LOW_EN;
      st_r.skew.out1  <= `CMSR_RST_SKEW1;
      st_r.skew.out2  <= `CMSR_RST_SKEW2;
      st_r.skew.out3  <= `CMSR_RST_SKEW3;
      st_r.skew.out4  <= `CMSR_RST_SKEW4;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // per-input monitor setup
  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_input
    cmsr_los_decode u_dec
    (
      .sel_high_in (st_r.sel_high[`CMSR_SEL_HIGH_LSB + i]),
      .sel_low_in  (st_r.sel_low_en[`CMSR_SEL_LOW_LSB + i]),
      .cfg_out     (loss_cfg_out[i])
    );
    assign offset_monitor_enable_out[i] =
      st_r.sel_low_en[`CMSR_OFS_EN_LSB + i];
  end

  // ========================================================================
  // outputs
  assign reg_rdata_out  = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign phase_skew_out = st_r.skew;

endmodule : cmsr_regs

// >>> tb/cmsr_regs_checker.sv
`timescale 1ns/1ns
`include "cmsr_cfg.svh"
module cmsr_chk
#(
  parameter int NUM_INPUTS = 4
)
(
  input wire logic                                   mclk_in,
  input wire logic                                   nrst_in,
  input wire logic [7:0]                             reg_addr_in,
  input wire logic                                   reg_wr_in,
  input wire logic                                   reg_rd_in,
  input wire logic [7:0]                             reg_wdata_in,
  input wire logic [7:0]                             reg_rdata_out,
  input wire logic                                   reg_rvalid_out,
  input wire cmsr_pkg::cmsr_mon_cfg_t [NUM_INPUTS-1:0] loss_cfg_out,
  input wire logic [NUM_INPUTS-1:0]                  offset_monitor_enable_out,
  input wire cmsr_pkg::cmsr_skew_t                   phase_skew_out
);
  // ======================================================================
  // register port relations
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire w_hi = reg_wr_in && reg_addr_in == 8'h8A;
  wire w_lo = reg_wr_in && reg_addr_in == 8'h8B;
  property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("no read valid");
  property p_sk; reg_wr_in && reg_addr_in == 8'h8C |=>
    phase_skew_out.out1 == $past(reg_wdata_in); endproperty
  a_sk: assert property (p_sk) else $error("skew one not written");
  property p_of; w_lo |=> offset_monitor_enable_out ==
    $past(reg_wdata_in[3:0]); endproperty
  a_of: assert property (p_of) else $error("offset enable wrong");
  property p_lo; w_lo |=> loss_cfg_out[0].mode[0] == $past(reg_wdata_in[4]);
  endproperty
  a_lo: assert property (p_lo) else $error("low select bit wrong");
  property p_hi; w_hi |=> loss_cfg_out[3].mode[1] == $past(reg_wdata_in[3]);
  endproperty
  a_hi: assert property (p_hi) else $error("high select bit wrong");
  property p_off; loss_cfg_out[2].mode == cmsr_pkg::CMSR_LOS_OFF |->
    !loss_cfg_out[2].active; endproperty
  a_off: assert property (p_off) else $error("off monitor active");
  property p_red; loss_cfg_out[1].mode == cmsr_pkg::CMSR_LOS_REDUCED |->
    loss_cfg_out[1].window > `CMSR_WIN_FULL; endproperty
  a_red: assert property (p_red) else $error("reduced not slower");
  property p_rs; reg_rd_in && reg_addr_in == 8'h8A |=>
    reg_rdata_out[7:4] == 4'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved bits not zero");
endmodule : cmsr_chk
bind cmsr_regs cmsr_chk #(.NUM_INPUTS(NUM_INPUTS)) i_cmsr_chk (.*);

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                          mclk_in = 1'b0;
  logic                          nrst_in = 1'b0;
  logic [7:0]                    reg_addr_in = 8'h00;
  logic                          reg_wr_in = 1'b0;
  logic                          reg_rd_in = 1'b0;
  logic [7:0]                    reg_wdata_in = 8'h00;
  logic [7:0]                    reg_rdata_out;
  logic                          reg_rvalid_out;
  cmsr_pkg::cmsr_mon_cfg_t [3:0] loss_cfg_out;
  logic [3:0]                    offset_monitor_enable_out;
  cmsr_pkg::cmsr_skew_t          phase_skew_out;
  int                            n_mismatch = 0;
  int                            n_tests = 0;
  cmsr_regs #(.NUM_INPUTS(4)) i_cmsr_regs (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .loss_cfg_out(loss_cfg_out), .phase_skew_out(phase_skew_out),
    .offset_monitor_enable_out(offset_monitor_enable_out));
  initial forever #2 mclk_in = ~mclk_in;
  // ======================================================================
  // shared tasks
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    reg_rd_in = 1'b0;
    @(posedge mclk_in);
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    reg_wr_in = 1'b0;
    @(posedge mclk_in);
    #1;
    chk("rvalid", reg_rvalid_out, 32'h1);
    chk("rdata", reg_rdata_out, e);
  endtask : rd
  task automatic idle();
    reg_rd_in = 1'b0;
    reg_wr_in = 1'b0;
    @(posedge mclk_in);
    #1;
    chk("rvalid low", reg_rvalid_out, 32'h0);
  endtask : idle
  // ======================================================================
  // scenarios
  task automatic t_reset();
    chk("ofs reset", offset_monitor_enable_out, 32'hF);
    chk("mode reset", loss_cfg_out[3].mode, 32'h3);
    rd(8'h8B, 8'hFF);
    rd(8'h8D, 8'h01);
    rd(8'h8E, 8'h00);
    rd(8'h8A, 8'h0F);
    idle();
    $display("t_reset done");
  endtask : t_reset
  task automatic t_modes();
    logic [1:0] cd [3] = '{2'h0, 2'h2, 2'h3};
    logic [3:0] of [3] = '{4'h5, 4'hA, 4'h0};
    logic [1:0] c [4];
    logic [3:0] hi;
    logic [3:0] lo;
    for (int k = 0; k < 3; k++)
    begin
      for (int i = 0; i < 4; i++)
        c[i] = cd[(i + k) % 3];
      hi = {c[3][1], c[2][1], c[1][1], c[0][1]};
      lo = {c[3][0], c[2][0], c[1][0], c[0][0]};
      wr(8'h8A, {4'hF, hi});
      wr(8'h8B, {lo, of[k]});
      for (int i = 0; i < 4; i++)
      begin
        chk("mode", loss_cfg_out[i].mode, c[i]);
        chk("active", loss_cfg_out[i].active, c[i] != 2'h0);
      end
      chk("ofs", offset_monitor_enable_out, of[k]);
      rd(8'h8A, {4'h0, hi});
    end
    idle();
    $display("t_modes done");
  endtask : t_modes
  task automatic t_skew();
    logic [7:0] v [4] = '{8'h80, 8'h7F, 8'hFF, 8'h01};
    for (int i = 0; i < 4; i++)
      wr(8'h8C + 8'(i), v[i]);
    wr(8'h89, 8'h33);
    chk("skew", phase_skew_out, 32'h01FF7F80);
    for (int i = 0; i < 4; i++)
      rd(8'h8C + 8'(i), v[i]);
    rd(8'h90, 8'h00);
    idle();
    $display("t_skew done");
  endtask : t_skew
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (10) @(posedge mclk_in);
    #1;
    nrst_in = 1'b1;
    t_reset();
    t_modes();
    t_skew();
    nrst_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
    nrst_in = 1'b1;
    t_reset();
    end_of_test();
  end
endmodule : tb_top
